// file: rtl/thci_pkg.sv
package thci_pkg;
	// timing
	localparam int CLK_PERIOD_NS    = 50;
	localparam int SCL_PERIOD_NS    = 1200;
	localparam int SCL_QTR_CYC      = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	localparam int STRAP_SETTLE_CYC = 4;
	localparam int SEQ_W            = 6;

	// serial target addressing
	localparam logic [6:0] TGT_ADDR     = 7'h25;
	localparam logic [7:0] ADDR_WR_BYTE = {TGT_ADDR, 1'b0};
	localparam logic [7:0] ADDR_RD_BYTE = {TGT_ADDR, 1'b1};

	// device map layout
	localparam logic [7:0] STATUS_REG      = 8'h00;
	localparam int         NUMT_W          = 4;
	localparam logic [7:0] STREAM_OUT_BASE = 8'h80;
	localparam logic [7:0] STREAM_IN_BASE  = 8'hC0;

	// reports
	localparam logic [7:0] TOUCH_RPT_ID    = 8'h01;
	localparam logic [7:0] GEN_RPT_ID      = 8'h05;
	localparam logic [5:0] TOUCH_CNT_OFS   = 6'h35;
	localparam logic [5:0] GEN_MAX_PAYLOAD = 6'h3E;
	localparam logic [1:0] EP_TOUCH        = 2'h1;
	localparam logic [1:0] EP_GEN          = 2'h2;

	// host controller registers
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PTR    = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_MASK   = 8'h14;
	localparam logic [7:0] REG_INFO   = 8'h18;
	localparam logic [7:0] REG_CFG    = 8'h1C;
	localparam int CTRL_I2C_WR = 0;
	localparam int CTRL_I2C_RD = 1;
	localparam int CTRL_GEN_TX = 2;
	localparam int ST_W        = 4;
	localparam int ST_DONE     = 0;
	localparam int ST_NACK     = 1;
	localparam int ST_D2H      = 2;
	localparam int ST_DEVIRQ   = 3;
	localparam logic CFG_SEL_RST = 1'b1;

	typedef enum logic [2:0] {ACT_START, ACT_RSTART, ACT_WBYTE, ACT_RBYTE, ACT_STOP} thci_act_e;
endpackage

// file: rtl/thci_if.sv
`timescale 1ns/1ns
`default_nettype none
interface thci_if ();
	logic       interface_select_pin;
	logic       scl;
	logic       sda_host_oe;
	logic       sda_dev_oe;
	logic       sda;
	logic       dev_irq_n;
	logic       d2h_valid;
	logic [7:0] d2h_data;
	logic       d2h_last;
	logic [1:0] d2h_ep;
	logic       h2d_valid;
	logic [7:0] h2d_data;
	logic       h2d_last;

	// open-drain line with pull-up
	assign sda = !(sda_host_oe || sda_dev_oe);

	modport dev (
		input  interface_select_pin, scl, sda, h2d_valid, h2d_data, h2d_last,
		output sda_dev_oe, dev_irq_n, d2h_valid, d2h_data, d2h_last, d2h_ep
	);
	modport host (
		input  sda, dev_irq_n, d2h_valid, d2h_data, d2h_last, d2h_ep,
		output interface_select_pin, scl, sda_host_oe, h2d_valid, h2d_data, h2d_last
	);
endinterface
`default_nettype wire

// file: rtl/thci_device.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module thci_device
	import thci_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// link
	thci_if.dev             link,
	// map loading
	input  wire logic       map_we,
	input  wire logic [7:0] map_addr,
	input  wire logic [7:0] map_wdata,
	// usb report requests
	input  wire logic       send_touch,
	input  wire logic       send_gen,
	input  wire logic [5:0] gen_len,
	// interrupt source
	input  wire logic       irq_enable,
	input  wire logic       irq_req,
	// status
	output logic            mode_valid,
	output logic            mode_i2c,
	output logic            host_wr_valid,
	output logic [7:0]      host_wr_addr,
	output logic [7:0]      host_wr_data,
	output logic            gen_rx_done,
	output logic            gen_rx_bad,
	output logic [5:0]      gen_rx_seq
);
	import thci_pkg::*;

	typedef enum {SL_IDLE, SL_ADDR, SL_PTR, SL_WR, SL_RD} thci_slv_e;

	logic [7:0]       map_q [256];
	logic [2:0]       s1_q, s2_q, s3_q, f_q, fp_q;
	logic [2:0]       settle_q;
	logic             i2c_on, usb_on;
	logic             scl_rise, scl_fall, start_ev, stop_ev;
	thci_slv_e        st_q;
	logic [3:0]       bit_q;
	logic             ack_q, rw_q, mack_q, oe_q, irq_n_q;
	logic [7:0]       ptr_q, sh_q, tx_q;
	logic             i2c_wr, rd_load;
	logic             tx_busy_q, tx_gen_q, d2h_v_q, d2h_l_q;
	logic [5:0]       tx_idx_q, tx_end_q, seq_out_q;
	logic [7:0]       d2h_d_q, tx_byte;
	logic [1:0]       d2h_ep_q;
	logic [5:0]       rx_idx_q;
	logic             rx_drop_q, rx_drop, usb_wr;

	// bit order: 2 = select strap, 1 = scl, 0 = sda
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q <= 3'h3;
			s2_q <= 3'h3;
			s3_q <= 3'h3;
			f_q  <= 3'h3;
			fp_q <= 3'h3;
		end else begin
			s1_q <= {link.interface_select_pin, link.scl, link.sda};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
			fp_q <= f_q;
		end
	end

	// the strap is caught after the filter has settled, never during reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			settle_q   <= '0;
			mode_valid <= 1'b0;
			mode_i2c   <= 1'b0;
		end else if (!mode_valid) begin
			settle_q <= settle_q + 3'h1;
			if (settle_q == 3'(STRAP_SETTLE_CYC)) begin
				mode_valid <= 1'b1;
				mode_i2c   <= f_q[2];
			end
		end
	end

	assign i2c_on   = mode_valid && mode_i2c;
	assign usb_on   = mode_valid && !mode_i2c;
	assign scl_rise = f_q[1] && !fp_q[1];
	assign scl_fall = !f_q[1] && fp_q[1];
	assign start_ev = f_q[1] && fp_q[1] && !f_q[0] && fp_q[0];
	assign stop_ev  = f_q[1] && fp_q[1] && f_q[0] && !fp_q[0];
	assign i2c_wr   = i2c_on && scl_fall && !ack_q && bit_q == 4'h8 && st_q == SL_WR;
	assign rd_load  = i2c_on && scl_fall && ack_q
		&& ((st_q == SL_ADDR && rw_q) || (st_q == SL_RD && mack_q));

	// serial target engine
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !i2c_on) begin
			st_q   <= SL_IDLE;
			bit_q  <= '0;
			ack_q  <= 1'b0;
			rw_q   <= 1'b0;
			mack_q <= 1'b0;
			oe_q   <= 1'b0;
			ptr_q  <= '0;
			sh_q   <= '0;
			tx_q   <= '0;
		end else if (start_ev) begin
			st_q  <= SL_ADDR;
			bit_q <= '0;
			ack_q <= 1'b0;
			oe_q  <= 1'b0;
		end else if (stop_ev) begin
			st_q  <= SL_IDLE;
			ack_q <= 1'b0;
			oe_q  <= 1'b0;
		end else if (st_q != SL_IDLE && scl_rise) begin
			if (ack_q) begin
				mack_q <= !f_q[0];
			end else begin
				sh_q  <= {sh_q[6:0], f_q[0]};
				bit_q <= bit_q + 4'h1;
			end
		end else if (st_q != SL_IDLE && scl_fall) begin
			if (ack_q) begin
				ack_q <= 1'b0;
				bit_q <= '0;
				oe_q  <= 1'b0;
				unique case (st_q)
					SL_ADDR: begin
						if (rw_q) begin
							st_q <= SL_RD;
						end else begin
							st_q <= SL_PTR;
						end
					end
					SL_PTR: st_q <= SL_WR;
					SL_RD: begin
						if (!mack_q) begin
							st_q <= SL_IDLE;
						end
					end
					SL_WR, SL_IDLE: ;
				endcase
				if (rd_load) begin
					tx_q <= map_q[ptr_q];
					oe_q <= !map_q[ptr_q][7];
				end
			end else if (bit_q == 4'h8) begin
				ack_q <= 1'b1;
				unique case (st_q)
					SL_ADDR: begin
						if (sh_q[7:1] == TGT_ADDR) begin
							rw_q <= sh_q[0];
							oe_q <= 1'b1;
						end else begin
							st_q <= SL_IDLE;
						end
					end
					SL_PTR: begin
						ptr_q <= sh_q;
						oe_q  <= 1'b1;
					end
					SL_WR: begin
						ptr_q <= ptr_q + 8'h1;
						oe_q  <= 1'b1;
					end
					SL_RD: begin
						ptr_q <= ptr_q + 8'h1;
						oe_q  <= 1'b0; // let the master ack or nack
					end
					SL_IDLE: ;
				endcase
			end else if (st_q == SL_RD) begin
				tx_q <= {tx_q[6:0], 1'b0};
				oe_q <= !tx_q[6];
			end
		end
	end

	assign link.sda_dev_oe = oe_q;

	// interrupt: a request in the same cycle as a status read still wins
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_n_q <= 1'b1;
		end else if (i2c_on && irq_enable && irq_req) begin
			irq_n_q <= 1'b0;
		end else if (rd_load && ptr_q == STATUS_REG) begin
			irq_n_q <= 1'b1;
		end
	end

	assign link.dev_irq_n = irq_n_q;

	// register map and stream buffers, serial writes first
	always_ff @(posedge clk_sys) begin
		if (i2c_wr) begin
			map_q[ptr_q] <= sh_q;
		end else if (usb_wr) begin
			map_q[8'(STREAM_IN_BASE + {2'h0, rx_idx_q} - 8'h2)] <= link.h2d_data;
		end else if (map_we) begin
			map_q[map_addr] <= map_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			host_wr_valid <= 1'b0;
			host_wr_addr  <= '0;
			host_wr_data  <= '0;
		end else begin
			host_wr_valid <= i2c_wr;
			if (i2c_wr) begin
				host_wr_addr <= ptr_q;
				host_wr_data <= sh_q;
			end
		end
	end

	// usb report bytes
	always_comb begin
		tx_byte = map_q[{2'h0, tx_idx_q}];
		if (tx_idx_q == 6'h0) begin
			tx_byte = tx_gen_q ? GEN_RPT_ID : TOUCH_RPT_ID;
		end else if (tx_gen_q) begin
			if (tx_idx_q == 6'h1) begin
				tx_byte = {2'h0, seq_out_q};
			end else begin
				tx_byte = map_q[8'(STREAM_OUT_BASE + {2'h0, tx_idx_q} - 8'h2)];
			end
		end else if (tx_idx_q == TOUCH_CNT_OFS) begin
			tx_byte = {{(8 - NUMT_W){1'b0}}, map_q[STATUS_REG][NUMT_W-1:0]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_busy_q <= 1'b0;
			tx_gen_q  <= 1'b0;
			tx_idx_q  <= '0;
			tx_end_q  <= '0;
			seq_out_q <= '0;
			d2h_v_q   <= 1'b0;
			d2h_l_q   <= 1'b0;
			d2h_d_q   <= '0;
			d2h_ep_q  <= EP_TOUCH;
		end else if (!tx_busy_q) begin
			d2h_v_q <= 1'b0;
			d2h_l_q <= 1'b0;
			tx_idx_q <= '0;
			if (usb_on && (send_touch || send_gen)) begin
				tx_busy_q <= 1'b1;
				tx_gen_q  <= !send_touch;
				tx_end_q  <= send_touch ? TOUCH_CNT_OFS
					: ((gen_len > GEN_MAX_PAYLOAD) ? GEN_MAX_PAYLOAD : gen_len) + 6'h1;
			end
		end else begin
			d2h_v_q  <= 1'b1;
			d2h_d_q  <= tx_byte;
			d2h_ep_q <= tx_gen_q ? EP_GEN : EP_TOUCH;
			d2h_l_q  <= tx_idx_q == tx_end_q;
			tx_idx_q <= tx_idx_q + 6'h1;
			if (tx_idx_q == tx_end_q) begin
				tx_busy_q <= 1'b0;
				if (tx_gen_q) begin
					seq_out_q <= seq_out_q + 6'h1;
				end
			end
		end
	end

	assign link.d2h_valid = d2h_v_q;
	assign link.d2h_data  = d2h_d_q;
	assign link.d2h_last  = d2h_l_q;
	assign link.d2h_ep    = d2h_ep_q;

	// usb stream reception; bytes past the buffer keep overwriting its last byte
	assign rx_drop = (rx_idx_q == 6'h0) ? (link.h2d_data != GEN_RPT_ID) : rx_drop_q;
	assign usb_wr  = usb_on && link.h2d_valid && rx_idx_q >= 6'h2 && !rx_drop_q
		&& rx_idx_q <= GEN_MAX_PAYLOAD + 6'h1;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_idx_q    <= '0;
			rx_drop_q   <= 1'b0;
			gen_rx_seq  <= '0;
			gen_rx_done <= 1'b0;
			gen_rx_bad  <= 1'b0;
		end else begin
			gen_rx_done <= 1'b0;
			gen_rx_bad  <= 1'b0;
			if (usb_on && link.h2d_valid) begin
				rx_drop_q <= rx_drop;
				if (rx_idx_q == 6'h1 && !rx_drop_q) begin
					gen_rx_seq <= link.h2d_data[SEQ_W-1:0];
				end
				if (link.h2d_last) begin
					rx_idx_q    <= '0;
					gen_rx_done <= !rx_drop;
					gen_rx_bad  <= rx_drop;
				end else if (rx_idx_q != 6'h3F) begin
					rx_idx_q <= rx_idx_q + 6'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/thci_host.sv
`timescale 1ns/1ns
`default_nettype none
module thci_host
	import thci_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// link
	thci_if.host             link,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// interrupt
	output logic             irq
);
	import thci_pkg::*;

	logic             sel_q, busy_q, rd_op_q, scl_q, oe_q, nack_q;
	logic [7:0]       ptr_q, wdata_q, rdata_q, sh_q;
	logic [ST_W-1:0]  stat_q, mask_q, set_ev;
	logic [2:0]       sd1_q, sd2_q, sd3_q, sdf_q, step_q;
	logic             sda_f, irq_f;
	logic [1:0]       q_q;
	logic [3:0]       bit_q;
	logic [4:0]       qcnt_q;
	logic             tick, last_q, done_ev, nack_ev;
	thci_act_e        act;
	logic [7:0]       wbyte;
	logic             lvl_scl, lvl_sda;
	logic [1:0]       h_idx_q;
	logic             h_busy_q, h_v_q, h_l_q;
	logic [7:0]       h_d_q;
	logic [5:0]       h_seq_q, d_seq_q;
	logic [7:0]       d_id_q, d_cnt_q;
	logic [5:0]       d_idx_q;

	// pin inputs: 0 = sda, 1 = interrupt line (active low)
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sd1_q <= 3'h3;
			sd2_q <= 3'h3;
			sd3_q <= 3'h3;
			sdf_q <= 3'h3;
		end else begin
			sd1_q <= {1'b0, link.dev_irq_n, link.sda};
			sd2_q <= sd1_q;
			sd3_q <= sd2_q;
			// a change counts only once flops two and three agree
			sdf_q <= (sd2_q & ~(sd2_q ^ sd3_q)) | (sdf_q & (sd2_q ^ sd3_q));
		end
	end
	assign sda_f = sdf_q[0];
	assign irq_f = !sdf_q[1];

	always_comb begin
		act   = ACT_STOP;
		wbyte = ADDR_WR_BYTE;
		unique case (step_q)
			3'h0: act = ACT_START;
			3'h1: act = ACT_WBYTE;
			3'h2: begin
				act   = ACT_WBYTE;
				wbyte = ptr_q;
			end
			3'h3: begin
				act   = rd_op_q ? ACT_RSTART : ACT_WBYTE;
				wbyte = wdata_q;
			end
			3'h4: begin
				act   = rd_op_q ? ACT_WBYTE : ACT_STOP;
				wbyte = ADDR_RD_BYTE;
			end
			3'h5: act = rd_op_q ? ACT_RBYTE : ACT_STOP;
			default: act = ACT_STOP;
		endcase
	end

	always_comb begin
		lvl_scl = q_q == 2'h1 || q_q == 2'h2;
		lvl_sda = (act == ACT_WBYTE && bit_q != 4'h8) ? wbyte[3'(4'h7 - bit_q)] : 1'b1;
		unique case (act)
			ACT_START: begin
				lvl_scl = q_q != 2'h2;
				lvl_sda = q_q == 2'h0;
			end
			ACT_RSTART: lvl_sda = q_q < 2'h2;
			ACT_STOP: lvl_sda = q_q == 2'h2;
			ACT_WBYTE, ACT_RBYTE: ;
		endcase
	end

	assign tick    = qcnt_q == 5'(SCL_QTR_CYC - 1);
	assign last_q  = (act == ACT_START || act == ACT_STOP) ? q_q == 2'h2 : q_q == 2'h3;
	assign nack_ev = busy_q && tick && act == ACT_WBYTE && q_q == 2'h2 && bit_q == 4'h8 && sda_f;
	assign done_ev = busy_q && tick && act == ACT_STOP && last_q;

	// serial master: start, address, pointer, then data or restart-read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_q  <= 1'b0;
			rd_op_q <= 1'b0;
			step_q  <= '0;
			q_q     <= '0;
			bit_q   <= '0;
			qcnt_q  <= '0;
			nack_q  <= 1'b0;
			sh_q    <= '0;
			rdata_q <= '0;
			scl_q   <= 1'b1;
			oe_q    <= 1'b0;
		end else if (!busy_q) begin
			scl_q  <= 1'b1;
			oe_q   <= 1'b0;
			step_q <= '0;
			q_q    <= '0;
			bit_q  <= '0;
			qcnt_q <= '0;
			nack_q <= 1'b0;
			if (reg_wr && reg_addr == REG_CTRL && sel_q
				&& (reg_wdata[CTRL_I2C_WR] || reg_wdata[CTRL_I2C_RD])) begin
				busy_q  <= 1'b1;
				rd_op_q <= !reg_wdata[CTRL_I2C_WR];
			end
		end else begin
			scl_q  <= lvl_scl;
			oe_q   <= !lvl_sda;
			qcnt_q <= tick ? 5'h0 : qcnt_q + 5'h1;
			if (tick) begin
				if (act == ACT_RBYTE && q_q == 2'h2 && bit_q != 4'h8) begin
					sh_q <= {sh_q[6:0], sda_f};
				end
				if (nack_ev) begin
					nack_q <= 1'b1;
				end
				q_q <= last_q ? 2'h0 : q_q + 2'h1;
				if (last_q) begin
					if ((act == ACT_WBYTE || act == ACT_RBYTE) && bit_q != 4'h8) begin
						bit_q <= bit_q + 4'h1;
					end else if (act == ACT_STOP) begin
						busy_q <= 1'b0;
						if (rd_op_q && !nack_q) begin
							rdata_q <= sh_q;
						end
					end else begin
						bit_q  <= '0;
						step_q <= nack_q ? (rd_op_q ? 3'h6 : 3'h4) : step_q + 3'h1;
					end
				end
			end
		end
	end

	assign link.scl         = scl_q;
	assign link.sda_host_oe = oe_q;

	// generic report out: id, own sequence, one payload byte
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			h_busy_q <= 1'b0;
			h_idx_q  <= '0;
			h_v_q    <= 1'b0;
			h_l_q    <= 1'b0;
			h_d_q    <= '0;
			h_seq_q  <= '0;
		end else if (!h_busy_q) begin
			h_v_q   <= 1'b0;
			h_l_q   <= 1'b0;
			h_idx_q <= '0;
			h_busy_q <= reg_wr && reg_addr == REG_CTRL && !sel_q && reg_wdata[CTRL_GEN_TX];
		end else begin
			h_v_q   <= 1'b1;
			h_idx_q <= h_idx_q + 2'h1;
			h_l_q   <= h_idx_q == 2'h2;
			h_d_q   <= (h_idx_q == 2'h0) ? GEN_RPT_ID
				: (h_idx_q == 2'h1) ? {2'h0, h_seq_q} : wdata_q;
			if (h_idx_q == 2'h2) begin
				h_busy_q <= 1'b0;
				h_seq_q  <= h_seq_q + 6'h1;
			end
		end
	end

	assign link.h2d_valid = h_v_q;
	assign link.h2d_data  = h_d_q;
	assign link.h2d_last  = h_l_q;

	// incoming reports: keep id, sequence and touch count
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			d_idx_q <= '0;
			d_id_q  <= '0;
			d_seq_q <= '0;
			d_cnt_q <= '0;
		end else if (link.d2h_valid) begin
			d_idx_q <= link.d2h_last ? 6'h0 : d_idx_q + 6'h1;
			if (d_idx_q == 6'h0) begin
				d_id_q <= link.d2h_data;
			end
			if (d_idx_q == 6'h1 && link.d2h_ep == EP_GEN) begin
				d_seq_q <= link.d2h_data[SEQ_W-1:0];
			end
			if (d_idx_q == TOUCH_CNT_OFS && link.d2h_ep == EP_TOUCH) begin
				d_cnt_q <= link.d2h_data;
			end
		end
	end

	always_comb begin
		set_ev            = '0;
		set_ev[ST_DONE]   = done_ev;
		set_ev[ST_NACK]   = nack_ev;
		set_ev[ST_D2H]    = link.d2h_valid && link.d2h_last;
		set_ev[ST_DEVIRQ] = irq_f;
	end

	// registers; a new event beats a write-one-to-clear of the same bit
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_q     <= CFG_SEL_RST;
			ptr_q     <= '0;
			wdata_q   <= '0;
			stat_q    <= '0;
			mask_q    <= '0;
			irq       <= 1'b0;
			reg_rdata <= '0;
		end else begin
			if (reg_wr && reg_addr == REG_CFG) begin
				sel_q <= reg_wdata[0];
			end
			if (reg_wr && reg_addr == REG_PTR) begin
				ptr_q <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == REG_WDATA) begin
				wdata_q <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == REG_MASK) begin
				mask_q <= reg_wdata[ST_W-1:0];
			end
			stat_q <= (stat_q & ~((reg_wr && reg_addr == REG_STATUS) ? reg_wdata[ST_W-1:0] : '0))
				| set_ev;
			irq <= |(stat_q & mask_q);
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					REG_CTRL:   reg_rdata <= {30'h0, h_busy_q, busy_q};
					REG_PTR:    reg_rdata <= {24'h0, ptr_q};
					REG_WDATA:  reg_rdata <= {24'h0, wdata_q};
					REG_RDATA:  reg_rdata <= {24'h0, rdata_q};
					REG_STATUS: reg_rdata <= {{(32 - ST_W){1'b0}}, stat_q};
					REG_MASK:   reg_rdata <= {{(32 - ST_W){1'b0}}, mask_q};
					REG_INFO:   reg_rdata <= {d_cnt_q, d_id_q, 2'h0, h_seq_q, 2'h0, d_seq_q};
					REG_CFG:    reg_rdata <= {31'h0, sel_q};
					default:    reg_rdata <= '0;
				endcase
			end
		end
	end

	assign link.interface_select_pin = sel_q;
endmodule
`default_nettype wire

// file: verif/thci_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module thci_monitor
	import thci_pkg::*;
(
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	// link
	input wire logic       scl,
	input wire logic       sda_dev_oe,
	input wire logic       d2h_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_last,
	input wire logic [1:0] d2h_ep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	logic       vld_q;
	logic       seq_q;
	logic       have_q;
	logic [5:0] last_q;

	// seq_q marks the sequence byte of a generic report
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			vld_q <= 1'h0;
			seq_q <= 1'h0;
			have_q <= 1'h0;
			last_q <= 6'h00;
		end else begin
			vld_q <= d2h_valid;
			seq_q <= d2h_valid && !vld_q && d2h_ep == EP_GEN;
			if (seq_q) begin
				have_q <= 1'h1;
				last_q <= d2h_data[5:0];
			end
		end
	end

	sequence s_start(logic [1:0] ep);
		d2h_valid && !vld_q && d2h_ep == ep;
	endsequence
	sequence s_touch_end;
		##53 (d2h_valid && d2h_last);
	endsequence

	property p_touch_id;
		s_start(EP_TOUCH) |-> d2h_data == TOUCH_RPT_ID;
	endproperty
	property p_touch_len;
		s_start(EP_TOUCH) |-> s_touch_end;
	endproperty
	property p_gen_id;
		s_start(EP_GEN) |-> d2h_data == GEN_RPT_ID;
	endproperty
	property p_seq_rsv;
		s_start(EP_GEN) |=> d2h_valid && d2h_data[7:6] == 2'h0;
	endproperty
	property p_seq_step;
		seq_q && have_q |-> d2h_data[5:0] == last_q + 6'h01;
	endproperty
	property p_ep_hold;
		d2h_valid && !d2h_last |=> d2h_valid && $stable(d2h_ep);
	endproperty
	property p_gap;
		d2h_valid && d2h_last |=> !d2h_valid;
	endproperty
	property p_sda_slot;
		$changed(sda_dev_oe) |-> !scl;
	endproperty

	a_touch_id: assert property (p_touch_id)
		else $error("touch report id wrong");
	a_touch_len: assert property (p_touch_len)
		else $error("touch count byte not last at 53");
	a_gen_id: assert property (p_gen_id)
		else $error("generic report id wrong");
	a_seq_rsv: assert property (p_seq_rsv)
		else $error("sequence reserved bits set");
	a_seq_step: assert property (p_seq_step)
		else $error("sequence did not step by one");
	a_ep_hold: assert property (p_ep_hold)
		else $error("endpoint changed inside report");
	a_gap: assert property (p_gap)
		else $error("no idle after report");
	a_sda_slot: assert property (p_sda_slot)
		else $error("data line changed with clock high");
endmodule
`default_nettype wire

// file: verif/tb_touch_host_comm_interface.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, a); end end
module tb_touch_host_comm_interface;
	import thci_pkg::*;
	logic        clk_sys = 1'h0;
	logic        sys_rst = 1'h1;
	logic        dev_rst = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic        map_we = 1'h0;
	logic [7:0]  map_addr = 8'h00;
	logic [7:0]  map_wdata = 8'h00;
	logic        send_touch = 1'h0;
	logic        send_gen = 1'h0;
	logic [5:0]  gen_len = 6'h00;
	logic        irq_enable = 1'h0;
	logic        irq_req = 1'h0;
	logic [31:0] seed = 32'h0001_158F;
	logic [31:0] reg_rdata, d, r;
	logic        irq, mode_valid, mode_i2c, host_wr_valid, gen_rx_done, gen_rx_bad;
	logic [7:0]  host_wr_addr, host_wr_data, ed;
	logic [5:0]  gen_rx_seq, es;
	logic [15:0] ew;
	logic [7:0]  eq[$];
	logic [15:0] wq[$];
	logic [5:0]  rq[$];
	int          fail_count = 0;
	int          num_checks = 0;
	int          i;
	wire logic   drst = sys_rst | dev_rst;

	thci_if link ();
	thci_host u_thci_host (.clk_sys, .sys_rst, .link(link.host), .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq);
	thci_device u_thci_device (.clk_sys, .sys_rst(drst), .link(link.dev), .map_we, .map_addr,
		.map_wdata, .send_touch, .send_gen, .gen_len, .irq_enable, .irq_req, .mode_valid,
		.mode_i2c, .host_wr_valid, .host_wr_addr, .host_wr_data, .gen_rx_done, .gen_rx_bad,
		.gen_rx_seq);
	thci_monitor u_thci_monitor (.clk_sys, .sys_rst(drst), .scl(link.scl),
		.sda_dev_oe(link.sda_dev_oe), .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data),
		.d2h_last(link.d2h_last), .d2h_ep(link.d2h_ep));

	initial forever #25 clk_sys = ~clk_sys;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task test_done();
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task hang();
		fail_count++;
		test_done();
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask

	task mw(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		map_we <= 1'h1;
		map_addr <= a;
		map_wdata <= v;
		@(posedge clk_sys);
		map_we <= 1'h0;
	endtask

	// every queued result must have shown up before this returns
	task wait_q();
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge clk_sys);
			#1;
			if (eq.size() + wq.size() + rq.size() == 0)
				break;
		end
		if (n == 300)
			hang();
	endtask

	task wait_mode(input logic exp);
		int n;
		for (n = 0; n < 50 && mode_valid !== 1'h1; n++)
			@(posedge clk_sys);
		if (mode_valid !== 1'h1)
			hang();
		`CHK("mode", exp, mode_i2c)
	endtask

	task i2c(input logic [7:0] p, input logic [7:0] w, input logic wrt);
		int n;
		wr(REG_PTR, {24'h00_0000, p});
		wr(REG_WDATA, {24'h00_0000, w});
		wr(REG_CTRL, wrt ? 32'h0000_0001 : 32'h0000_0002);
		d = 32'h0000_0000;
		for (n = 0; n < 1000 && d[ST_DONE] !== 1'h1; n++)
			rd(REG_STATUS, d);
		if (d[ST_DONE] !== 1'h1)
			hang();
		`CHK("nack", 1'h0, d[ST_NACK])
		wr(REG_STATUS, 32'h0000_0003);
		wait_q();
	endtask

	task pulse(input logic touch);
		@(posedge clk_sys);
		send_touch <= touch;
		send_gen <= !touch;
		@(posedge clk_sys);
		send_touch <= 1'h0;
		send_gen <= 1'h0;
		wait_q();
	endtask

	// takes the oldest note whenever a result appears
	always @(posedge clk_sys) begin
		if (link.d2h_valid === 1'h1) begin
			ed = eq.size() ? eq.pop_front() : 8'hxx;
			`CHK("d2h byte", ed, link.d2h_data)
		end
		if (host_wr_valid === 1'h1) begin
			ew = wq.size() ? wq.pop_front() : 16'hxxxx;
			`CHK("stored", ew, {host_wr_addr, host_wr_data})
		end
		if (gen_rx_done === 1'h1 || gen_rx_bad === 1'h1) begin
			es = rq.size() ? rq.pop_front() : 6'hxx;
			`CHK("rx seq", es, gen_rx_seq)
			`CHK("rx bad", 1'h0, gen_rx_bad)
		end
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rd(REG_CFG, d);
		`CHK("cfg", 1'h1, d[0])
		rd(8'h20, d);
		`CHK("unmapped", 32'h0000_0000, d)
		wait_mode(1'h1);
		r = xs();
		wq.push_back({8'h10, r[7:0]});
		i2c(8'h10, r[7:0], 1'h1);
		mw(8'h22, r[15:8]);
		i2c(8'h22, 8'h00, 1'h0);
		rd(REG_RDATA, d);
		`CHK("rdata", r[15:8], d[7:0])
		// interrupt raised while masked, then unmasked, then cleared
		irq_enable <= 1'h1;
		irq_req <= 1'h1;
		@(posedge clk_sys);
		irq_req <= 1'h0;
		repeat (12) @(posedge clk_sys);
		rd(REG_STATUS, d);
		`CHK("dev irq", 1'h1, d[ST_DEVIRQ])
		`CHK("irq masked", 1'h0, irq)
		wr(REG_MASK, 32'h0000_0008);
		repeat (4) @(posedge clk_sys);
		#1 `CHK("irq", 1'h1, irq)
		i2c(STATUS_REG, 8'h00, 1'h0);
		wr(REG_STATUS, 32'h0000_0008);
		repeat (4) @(posedge clk_sys);
		#1 `CHK("irq clr", 1'h0, irq)
		// strap low only takes effect at the next reset
		wr(REG_CFG, 32'h0000_0000);
		dev_rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		dev_rst <= 1'h0;
		wait_mode(1'h0);
		wr(REG_CFG, 32'h0000_0001);
		repeat (20) @(posedge clk_sys);
		`CHK("mode held", 1'h0, mode_i2c)
		wr(REG_CFG, 32'h0000_0000);
		eq.push_back(TOUCH_RPT_ID);
		for (i = 0; i < 53; i++) begin
			r = xs();
			if (i == 0)
				d = r;
			else
				eq.push_back(r[7:0]);
			mw(i[7:0], r[7:0]);
		end
		eq.push_back({4'h0, d[3:0]});
		pulse(1'h1);
		r[3:0] = d[3:0];
		rd(REG_INFO, d);
		`CHK("info cnt", {4'h0, r[3:0]}, d[31:24])
		`CHK("info id", TOUCH_RPT_ID, d[23:16])
		r = xs();
		mw(STREAM_OUT_BASE, r[7:0]);
		gen_len <= 6'h01;
		// 65 reports so the count wraps past 63
		for (i = 0; i < 65; i++) begin
			eq.push_back(GEN_RPT_ID);
			eq.push_back({2'h0, i[5:0]});
			eq.push_back(r[7:0]);
			pulse(1'h0);
		end
		rd(REG_INFO, d);
		`CHK("last seq", 6'h00, d[5:0])
		`CHK("info gen id", GEN_RPT_ID, d[23:16])
		`CHK("h2d seq", 6'h00, d[13:8])
		for (i = 0; i < 2; i++) begin
			rq.push_back(i[5:0]);
			wr(REG_WDATA, xs());
			wr(REG_CTRL, 32'h0000_0004);
			wait_q();
		end
		test_done();
	end
endmodule
`default_nettype wire
